// ==== hw/mlp_defs.vh ====
// Constants shared by the memory lock protection design files.
`ifndef MLP_DEFS_VH
`define MLP_DEFS_VH

// ----------------------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------------------
`define MLP_ADDR_W          4
`define MLP_ADDR_LOCK       4'h0
`define MLP_ADDR_CTRL       4'h1
`define MLP_ADDR_LOWDATA    4'h2
`define MLP_ADDR_MODES      4'h3
`define MLP_ADDR_VECT       4'h4
`define MLP_RDATA_IDLE      8'h00

// ----------------------------------------------------------------------------
// Lock byte layout
// ----------------------------------------------------------------------------
`define MLP_LOCK_ERASED     8'hff
`define MLP_LOCK_FIXED_ONES 8'hc0
`define MLP_LOCK_NONE       8'h00
`define MLP_SECT_LOCK_MASK  8'h3c
`define MLP_MEM_LOCK_MASK   8'h03
`define MLP_BOOT_SECT_MASK  8'h30
`define MLP_BIT_MEM_LO      0
`define MLP_BIT_MEM_HI      1
`define MLP_BIT_APP_LO      2
`define MLP_BIT_APP_HI      3
`define MLP_BIT_BOOT_LO     4
`define MLP_BIT_BOOT_HI     5

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define MLP_CTRL_SPM_EN     0
`define MLP_CTRL_LOCK_SET   3
`define MLP_CTRL_ARM_CODE   8'h09

// ----------------------------------------------------------------------------
// Timing: the armed lock-set command lasts four clock cycles.
// ----------------------------------------------------------------------------
`define MLP_ARM_W           3
`define MLP_ARM_CYCLES      3'd4
`define MLP_ARM_ZERO        3'd0
`define MLP_ARM_ONE         3'd1

// ----------------------------------------------------------------------------
// Section indices
// ----------------------------------------------------------------------------
`define MLP_SECT_APP        0
`define MLP_SECT_BOOT       1

`endif

// ==== hw/mlp_lock_store.v ====
// Lock byte storage cell: erase to ones, program bits to zero only.
`timescale 1ns/1ns
`default_nettype none
`include "mlp_defs.vh"

module mlp_lock_store (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       erase,
    input  wire       loadNv,
    input  wire [7:0] nvByte,
    input  wire [7:0] programMask,
    output reg  [7:0] lockByte
);

    reg [7:0] lock_next;

    // A bit returns to one only through erase; writes can only clear bits.
    always @* begin
        lock_next = lockByte;
        if (erase) begin
            lock_next = `MLP_LOCK_ERASED;
        end else if (loadNv) begin
            lock_next = nvByte | `MLP_LOCK_FIXED_ONES;
        end else begin
            lock_next = lockByte & ~(programMask & ~`MLP_LOCK_FIXED_ONES);
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lockByte <= `MLP_LOCK_ERASED;
        end else begin
            lockByte <= lock_next;
        end
    end

endmodule
`default_nettype wire

// ==== hw/mlp_section_gate.v ====
// Per-section decode of a lock pair into access and interrupt gating.
`timescale 1ns/1ns
`default_nettype none
`include "mlp_defs.vh"

module mlp_section_gate (
    input  wire       lockHi,
    input  wire       lockLo,
    input  wire       targetMine,
    input  wire       execMine,
    input  wire       vectorsMine,
    output wire [1:0] modeCode,
    output wire       writeBlock,
    output wire       readBlock,
    output wire       intBlock
);

    // Mode code is mode number minus one: 11->0, 10->1, 00->2, 01->3.
    assign modeCode   = {~lockHi, lockHi ^ lockLo};
    // Modes 2 and 3 have the low bit programmed and stop self-programming.
    assign writeBlock = targetMine & ~lockLo;
    // Modes 3 and 4 stop reads that come from code in the other section.
    assign readBlock  = targetMine & ~execMine & ~lockHi;
    // Modes 3 and 4 mask interrupts here when the vectors sit elsewhere.
    assign intBlock   = execMine & ~vectorsMine & ~lockHi;

endmodule
`default_nettype wire

// ==== hw/mlp_lock_ctrl.v ====
// Memory lock protection: lock byte, mode decode and access gating.
//
// Overview of operation
// - Six lock bits, one means unprogrammed; only chip erase returns them to one.
// - Boot pair at bits 5:4, application pair 3:2, memory lock 1:0, 7:6 read one.
// - Memory lock mode 1 leaves external programming and verification free.
// - Mode 2 blocks external flash, EEPROM and fuse writes; verify still allowed.
// - Mode 3 blocks external writes, verification, fuse and boot-lock changes.
// - Application mode 1 leaves self-writes and reads of that section free.
// - Application mode 2 suppresses self-writes into the application section.
// - Application mode 3 blocks self-writes and reads from boot code.
// - Application mode 4 allows self-writes but blocks reads from boot code.
// - Application modes 3 and 4 with vectors in boot mask interrupts in application.
// - Boot mode 1 leaves self-writes and reads of the boot section free.
// - Boot mode 2 suppresses self-writes into the boot section.
// - Boot mode 3 blocks self-writes and reads from application code.
// - Boot mode 4 allows self-writes but blocks reads from application code.
// - Boot modes 3 and 4 with vectors in application mask interrupts in boot.
// - Armed lock-set plus store within four cycles loads boot and application locks from low data.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "mlp_defs.vh"

module mlp_lock_ctrl (
    input  wire       ref_clk,
    input  wire       rst_n,
    // Register port.
    input  wire [3:0] regAddr,
    input  wire [7:0] regWdata,
    input  wire       regWrite,
    input  wire       regRead,
    output reg  [7:0] regRdata,
    // Nonvolatile lock cells and chip erase.
    input  wire [7:0] nvLockByte,
    input  wire       chipErase,
    // External programmer requests.
    input  wire       extFlashWr,
    input  wire       extEepromWr,
    input  wire       extVerifyRd,
    input  wire       extFuseWr,
    input  wire       extLockWr,
    input  wire [7:0] extLockData,
    output wire       extFlashWrOk,
    output wire       extEepromWrOk,
    output wire       extVerifyOk,
    output wire       extFuseWrOk,
    // CPU self-programming and program memory reads.
    input  wire       execInBoot,
    input  wire       selfWrReq,
    input  wire       selfWrToBoot,
    output wire       selfWrGrant,
    output wire       lockSetDone,
    input  wire       pmReadReq,
    input  wire       pmReadFromBoot,
    output wire       pmReadGrant,
    output wire       intDisable,
    output wire [7:0] lockByte
);

    // ------------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------------
    reg  [7:0]              lowData_reg;
    reg  [7:0]              lowData_next;
    reg                     vecInBoot_reg;
    reg                     vecInBoot_next;
    reg  [`MLP_ARM_W-1:0]   armCnt_reg;
    reg  [`MLP_ARM_W-1:0]   armCnt_next;
    reg                     loaded_reg;
    reg  [7:0]              rdata_next;
    wire                    ctrlWrite;
    wire                    armed;

    assign ctrlWrite = regWrite && (regAddr == `MLP_ADDR_CTRL);
    assign armed     = (armCnt_reg != `MLP_ARM_ZERO);

    // ------------------------------------------------------------------------
    // Lock byte storage
    // ------------------------------------------------------------------------
    wire [7:0] lockQ;
    wire [7:0] extMask;
    wire [7:0] selfMask;
    wire       memLockHi;
    wire       memLockLo;
    wire       lockSetFire;

    assign lockByte  = lockQ | `MLP_LOCK_FIXED_ONES;
    assign memLockHi = lockQ[`MLP_BIT_MEM_HI];
    assign memLockLo = lockQ[`MLP_BIT_MEM_LO];

    // A store issued while the command is armed sets boot and application locks (bits 5:2) only.
    assign lockSetFire = armed && selfWrReq;
    assign lockSetDone = lockSetFire;
    assign selfMask    = lockSetFire ? (~lowData_reg & `MLP_SECT_LOCK_MASK)
                                     : `MLP_LOCK_NONE;

    // The programmer may always program further memory lock bits; section
    // lock bits become frozen once mode 3 is reached.
    assign extMask = !extLockWr ? `MLP_LOCK_NONE
                   : (~extLockData & (memLockHi ? (`MLP_SECT_LOCK_MASK |
                                                   `MLP_MEM_LOCK_MASK)
                                                : `MLP_MEM_LOCK_MASK));

    mlp_lock_store u_store (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .erase       (chipErase),
        .loadNv      (~loaded_reg),
        .nvByte      (nvLockByte),
        .programMask (extMask | selfMask),
        .lockByte    (lockQ)
    );

    // ------------------------------------------------------------------------
    // External programming gates
    // ------------------------------------------------------------------------
    // Mode 1 is free; any programmed memory lock bit stops writes and fuse
    // changes; a programmed upper bit also stops verification.
    assign extFlashWrOk  = extFlashWr  && memLockLo && memLockHi;
    assign extEepromWrOk = extEepromWr && memLockLo && memLockHi;
    assign extFuseWrOk   = extFuseWr   && memLockLo && memLockHi;
    assign extVerifyOk   = extVerifyRd && memLockHi;

    // ------------------------------------------------------------------------
    // Section gates
    // ------------------------------------------------------------------------
    wire [1:0] secHi;
    wire [1:0] secLo;
    wire [1:0] secWrTarget;
    wire [1:0] secRdTarget;
    wire [1:0] secExec;
    wire [1:0] secVec;
    wire [1:0] secWrBlock;
    wire [1:0] secRdBlock;
    wire [1:0] secIntBlock;
    wire [3:0] secMode;

    assign secHi       = {lockQ[`MLP_BIT_BOOT_HI], lockQ[`MLP_BIT_APP_HI]};
    assign secLo       = {lockQ[`MLP_BIT_BOOT_LO], lockQ[`MLP_BIT_APP_LO]};
    assign secWrTarget = {selfWrToBoot, ~selfWrToBoot};
    assign secRdTarget = {pmReadFromBoot, ~pmReadFromBoot};
    assign secExec     = {execInBoot, ~execInBoot};
    assign secVec      = {vecInBoot_reg, ~vecInBoot_reg};

    genvar s;
    generate
        for (s = 0; s < 2; s = s + 1) begin : g_sect
            mlp_section_gate u_gate (
                .lockHi      (secHi[s]),
                .lockLo      (secLo[s]),
                .targetMine  (secWrTarget[s] | secRdTarget[s]),
                .execMine    (secExec[s]),
                .vectorsMine (secVec[s]),
                .modeCode    (secMode[2*s+1:2*s]),
                .writeBlock  (),
                .readBlock   (),
                .intBlock    (secIntBlock[s])
            );
            assign secWrBlock[s] = secWrTarget[s] & ~secLo[s];
            assign secRdBlock[s] = secRdTarget[s] & ~secExec[s] & ~secHi[s];
        end
    endgenerate

    // Grants are combinational so a blocked access never reaches the array.
    assign selfWrGrant = selfWrReq && !lockSetFire && (secWrBlock == 2'b00);
    assign pmReadGrant = pmReadReq && (secRdBlock == 2'b00);
    assign intDisable  = |secIntBlock;

    // ------------------------------------------------------------------------
    // Register writes and arming window
    // ------------------------------------------------------------------------
    always @* begin
        lowData_next   = lowData_reg;
        vecInBoot_next = vecInBoot_reg;
        armCnt_next    = armCnt_reg;
        if (regWrite && (regAddr == `MLP_ADDR_LOWDATA)) begin
            lowData_next = regWdata;
        end
        if (regWrite && (regAddr == `MLP_ADDR_VECT)) begin
            vecInBoot_next = regWdata[0];
        end
        if (ctrlWrite && (regWdata == `MLP_CTRL_ARM_CODE)) begin
            armCnt_next = `MLP_ARM_CYCLES;
        end else if (lockSetFire) begin
            armCnt_next = `MLP_ARM_ZERO;
        end else if (armed) begin
            armCnt_next = armCnt_reg - `MLP_ARM_ONE;
        end
    end

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    always @* begin
        rdata_next = `MLP_RDATA_IDLE;
        if (regRead) begin
            case (regAddr)
                `MLP_ADDR_LOCK: begin
                    rdata_next = lockByte;
                end
                `MLP_ADDR_CTRL: begin
                    rdata_next = armed ? `MLP_CTRL_ARM_CODE : `MLP_RDATA_IDLE;
                end
                `MLP_ADDR_LOWDATA: begin
                    rdata_next = lowData_reg;
                end
                `MLP_ADDR_MODES: begin
                    rdata_next = {2'b00, secMode[3:2], secMode[1:0],
                                  ~memLockHi, ~memLockLo};
                end
                `MLP_ADDR_VECT: begin
                    rdata_next = {7'h00, vecInBoot_reg};
                end
                default: begin
                    rdata_next = `MLP_RDATA_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowData_reg   <= `MLP_LOCK_ERASED;
            vecInBoot_reg <= 1'b0;
            armCnt_reg    <= `MLP_ARM_ZERO;
            loaded_reg    <= 1'b0;
            regRdata      <= `MLP_RDATA_IDLE;
        end else begin
            lowData_reg   <= lowData_next;
            vecInBoot_reg <= vecInBoot_next;
            armCnt_reg    <= armCnt_next;
            loaded_reg    <= 1'b1;
            regRdata      <= rdata_next;
        end
    end

endmodule
`default_nettype wire

// ==== tb/mlp_lock_ctrl_sva.sv ====
// Concurrent checks on the lock protection ports.
`timescale 1ns/1ns
`default_nettype none
module mlp_lock_ctrl_sva (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWrite,
    input wire logic       chipErase,
    input wire logic       extVerifyRd,
    input wire logic       extFuseWr,
    input wire logic       extVerifyOk,
    input wire logic       extFuseWrOk,
    input wire logic       execInBoot,
    input wire logic       selfWrReq,
    input wire logic       selfWrToBoot,
    input wire logic       selfWrGrant,
    input wire logic       lockSetDone,
    input wire logic       pmReadReq,
    input wire logic       pmReadFromBoot,
    input wire logic       pmReadGrant,
    input wire logic       intDisable,
    input wire logic [7:0] lockByte
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence arm_s;
        regWrite && regAddr == 4'h1 && regWdata == 8'h09;
    endsequence
    sequence store2_s;
        !selfWrReq ##1 selfWrReq;
    endsequence
    lock_set_a: assert property (arm_s ##1 store2_s |-> lockSetDone && !selfWrGrant)
        else $error("armed store not taken as lock set");
    sticky_bits_a: assert property (!chipErase |=> (lockByte & ~$past(lockByte)) == 8'h00)
        else $error("lock bit returned to one without erase");
    fuse_gate_a: assert property (extFuseWr |-> extFuseWrOk == (lockByte[1:0] == 2'b11))
        else $error("fuse write gate wrong");
    verify_gate_a: assert property (extVerifyRd |-> extVerifyOk == lockByte[1])
        else $error("verify gate wrong");
    app_write_a: assert property (selfWrReq && !selfWrToBoot && !lockSetDone
        |-> selfWrGrant == lockByte[2]) else $error("application write gate wrong");
    boot_write_a: assert property (selfWrReq && selfWrToBoot && !lockSetDone
        |-> selfWrGrant == lockByte[4]) else $error("boot write gate wrong");
    read_gate_a: assert property (pmReadReq |-> pmReadGrant ==
        (execInBoot == pmReadFromBoot || (pmReadFromBoot ? lockByte[5] : lockByte[3])))
        else $error("program read gate wrong");
    int_gate_a: assert property (intDisable |-> !(execInBoot ? lockByte[5] : lockByte[3]))
        else $error("interrupts masked in an open section");
endmodule
`default_nettype wire

// ==== tb/mlp_prog_model.sv ====
// Behavioural external programmer driving the lock block's programming port.
`timescale 1ns/1ns
`default_nettype none
module mlp_prog_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] reqCmd,
    input  wire logic       lockGo,
    input  wire logic [7:0] lockVal,
    output var  logic [3:0] extReq,
    output var  logic       extLockWr,
    output var  logic [7:0] extLockData
);
    logic       pendReg;
    logic [7:0] heldReg;
    // Section bits go out one cycle before the memory lock pair is touched.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            extReq      <= 4'h0;
            extLockWr   <= 1'h0;
            extLockData <= 8'h00;
            pendReg     <= 1'h0;
            heldReg     <= 8'hff;
        end else begin
            extReq    <= reqCmd;
            pendReg   <= lockGo;
            heldReg   <= lockVal;
            extLockWr <= lockGo | pendReg;
            if (lockGo) begin
                extLockData <= lockVal | 8'h03;
            end else if (pendReg) begin
                extLockData <= heldReg;
            end else begin
                extLockData <= ~extLockData;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the memory lock protection block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
    $display("MISMATCH %0t got %h want %h", $time, a, e); end end
module testbench;
    logic       ref_clk = 1'h0, rst_n = 1'h0, regWrite = 1'h0, regRead = 1'h0;
    logic       chipErase = 1'h0, execInBoot = 1'h0, selfWrReq = 1'h0, vect = 1'h0;
    logic       selfWrToBoot = 1'h0, pmReadReq = 1'h0, pmReadFromBoot = 1'h0;
    logic       lockGo = 1'h0, readPend = 1'h0, extLockWr, lockSetDone, intDisable;
    logic       extFlashWrOk, extEepromWrOk, extVerifyOk, extFuseWrOk, selfWrGrant, pmReadGrant;
    logic [3:0] regAddr = 4'h0, reqCmd = 4'h0, extReq;
    logic [7:0] regWdata = 8'h00, lockVal = 8'h00, nvLockByte, regRdata, extLockData;
    logic [7:0] lockByte, lk, lowD, ev, expQ[$];
    int         err_count = 0, samples_checked = 0, seed = 32'hce94, ds[3] = '{2, 4, 5};
    wire  [7:0] got = {extFlashWrOk, extEepromWrOk, extVerifyOk, extFuseWrOk, selfWrGrant,
        lockSetDone, pmReadGrant, intDisable} & {extReq, {2{selfWrReq}}, pmReadReq, 1'h1};
    always #10 ref_clk = ~ref_clk;
    mlp_prog_model prog_u (.ref_clk(ref_clk), .rst_n(rst_n), .reqCmd(reqCmd), .lockGo(lockGo),
        .lockVal(lockVal), .extReq(extReq), .extLockWr(extLockWr), .extLockData(extLockData));
    mlp_lock_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .nvLockByte(nvLockByte), .chipErase(chipErase), .extFlashWr(extReq[3]),
        .extEepromWr(extReq[2]), .extVerifyRd(extReq[1]), .extFuseWr(extReq[0]),
        .extLockWr(extLockWr), .extLockData(extLockData), .extFlashWrOk(extFlashWrOk),
        .extEepromWrOk(extEepromWrOk), .extVerifyOk(extVerifyOk), .extFuseWrOk(extFuseWrOk),
        .execInBoot(execInBoot), .selfWrReq(selfWrReq), .selfWrToBoot(selfWrToBoot),
        .selfWrGrant(selfWrGrant), .lockSetDone(lockSetDone), .pmReadReq(pmReadReq),
        .pmReadFromBoot(pmReadFromBoot), .pmReadGrant(pmReadGrant),
        .intDisable(intDisable), .lockByte(lockByte));
    function automatic logic [7:0] expv(input logic ex, input logic tb, input logic fb);
        logic ok;
        ok = lk[1:0] == 2'b11;
        expv = {ok, ok, lk[1], ok, tb ? lk[4] : lk[2], 1'h0,
            lk[fb ? 5 : 3] | (ex == fb), (vect != ex) & ~lk[ex ? 5 : 3]};
    endfunction
    task automatic print_verdict();
        $display("Checked %0d results, %0d mismatches", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        regWrite <= 1'h1;
        regAddr  <= a;
        regWdata <= v;
        @(posedge ref_clk);
        regWrite <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regRead <= 1'h1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge ref_clk);
        regRead <= 1'h0;
    endtask
    task automatic ext(input logic [3:0] c);
        @(posedge ref_clk);
        reqCmd <= c;
        expQ.push_back(expv(execInBoot, 1'h0, 1'h0) & {c, 4'h1});
        @(posedge ref_clk);
        reqCmd <= 4'h0;
        @(posedge ref_clk);
    endtask
    task automatic cpu(input logic ex, w, t, r, f, dn);
        @(posedge ref_clk);
        execInBoot     <= ex;
        selfWrReq      <= w;
        selfWrToBoot   <= t;
        pmReadReq      <= r;
        pmReadFromBoot <= f;
        expQ.push_back(expv(ex, t, f) & {4'h0, w & ~dn, 1'h0, r, 1'h1} | {5'h0, dn, 2'h0});
        @(posedge ref_clk);
        selfWrReq <= 1'h0;
        pmReadReq <= 1'h0;
        if (dn) lk[5:2] = lk[5:2] & lowD[5:2];
    endtask
    task automatic lockw(input logic [7:0] v);
        @(posedge ref_clk);
        lockGo  <= 1'h1;
        lockVal <= v;
        @(posedge ref_clk);
        lockGo <= 1'h0;
        repeat (2) @(posedge ref_clk);
        if (lk[1]) lk[5:2] = lk[5:2] & v[5:2];
        lk[1:0] = lk[1:0] & v[1:0];
    endtask
    task automatic erase();
        @(posedge ref_clk);
        chipErase <= 1'h1;
        @(posedge ref_clk);
        chipErase <= 1'h0;
        lk = 8'hff;
    endtask
    always @(posedge ref_clk) readPend <= regRead;
    always @(negedge ref_clk) begin
        if (readPend) begin
            ev = expQ.pop_front();
            `CHK(regRdata, ev)
        end else if (|{extReq, selfWrReq, pmReadReq}) begin
            ev = expQ.pop_front();
            `CHK(got, ev)
        end
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        print_verdict();
    end
    initial begin
        nvLockByte = $random(seed);
        lowD = $random(seed);
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'h1;
        lk = nvLockByte | 8'hc0;
        repeat (2) @(posedge ref_clk);
        rd(4'h0, lk);
        rd(4'h2, 8'hff);
        rd(4'hf, 8'h00);
        for (int m = 0; m < 16; m++) begin
            erase();
            lockw({2'h3, m[3:0], 2'h3});
            lockw(8'hff);
            rd(4'h0, lk);
            rd(4'h3, {2'h0, ~lk[5], ^lk[5:4], ~lk[3], ^lk[3:2], ~lk[1:0]});
            for (int k = 0; k < 8; k++) begin
                wr(4'h4, {7'h0, k[0]});
                vect = k[0];
                cpu(k[1], 1'h1, k[2], 1'h0, 1'h0, 1'h0);
                cpu(k[1], 1'h0, 1'h0, 1'h1, k[2], 1'h0);
            end
        end
        for (int m = 0; m < 4; m++) begin
            erase();
            lockw({6'h3f, m[1:0]});
            for (int c = 0; c < 4; c++)
                ext(4'h8 >> c);
            lockw(8'hc3);
            rd(4'h0, lk);
        end
        for (int i = 0; i < 3; i++) begin
            erase();
            wr(4'h2, lowD);
            wr(4'h1, 8'h09);
            repeat (ds[i] - 2) @(posedge ref_clk);
            cpu(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, ds[i] < 5);
            rd(4'h0, lk);
            lowD = $random(seed);
        end
        print_verdict();
    end
endmodule
bind mlp_lock_ctrl mlp_lock_ctrl_sva chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .chipErase(chipErase),
    .extVerifyRd(extVerifyRd), .extFuseWr(extFuseWr), .extVerifyOk(extVerifyOk),
    .extFuseWrOk(extFuseWrOk), .execInBoot(execInBoot), .selfWrReq(selfWrReq),
    .selfWrToBoot(selfWrToBoot), .selfWrGrant(selfWrGrant), .lockSetDone(lockSetDone),
    .pmReadReq(pmReadReq), .pmReadFromBoot(pmReadFromBoot), .pmReadGrant(pmReadGrant),
    .intDisable(intDisable), .lockByte(lockByte));
`default_nettype wire
